// ### hdl/exception_flag_bank.sv
// exception pending flags: hardware sets, software clears by writing zero.
// assumes set pulses and the write request are synchronous to pclk.
module exception_flag_bank (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // hardware events, one-cycle pulses
  input wire logic [23:0] set_events,
  // software clear request
  input wire exception_flag_pkg::flag_write_t wr,
  // flag state
  output logic [23:0] pending
);

  logic [23:0] pending_q;
  logic [23:0] pending_d;
  logic [23:0] clear_mask;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_lane
      // a one in the written byte leaves the flag alone; only zeros clear
      assign clear_mask[g*8 +: 8] = wr.byte_we[g] ? ~wr.data : 8'h00;
    end
  endgenerate

  // set is applied after clear so a coincident event survives the clear
  assign pending_d = ((pending_q & ~clear_mask) | set_events) & exception_flag_pkg::EXC_IMPLEMENTED;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending_q <= exception_flag_pkg::PENDING_RST;
    else
      pending_q <= pending_d;
  end

  assign pending = pending_q;

endmodule

// ### hdl/exception_flag_mask_unit.sv
// exception flag and channel A masking unit with its APB register slave.
// assumes APB signals synchronous to pclk and event inputs as one-cycle pulses.
//
// Function
// - receive enable mask bits 15:8 are a read/write byte at index 0x00F, reset zero.
// - each exception event sets its pending flag, which stays until software clears it.
// - pending flags clear only on written zeros; written ones leave the bit unchanged.
// - flags 7:0 at index 0x010: idle, tx done, ack, tx/rx buffer faults, enables cleared.
// - flags 15:8 at index 0x011: rx frame, filter, lookup, threshold, delimiter, crypto.
// - flags 22:16 at index 0x012: error events, unlock, abort, move timeout; 23 unused.
// - channel A has a 24-bit mask, one selects; bytes at 0x014, 0x015, 0x016, reset zero.
// - channel A output indicates when a selected exception occurs.
// - complement channel A output indicates when a masked exception occurs.
// - channel A mask bits 15:8 sit at their own index with the same meaning.
// - nonzero receive enable mask makes the radio control turn the receiver on.
module exception_flag_mask_unit (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // exception sources, one-cycle pulses
  input wire logic [23:0] exception_events,
  // channel A indications, one-cycle pulses
  output logic channel_a_indication,
  output logic channel_a_complement_indication,
  // receiver enable
  output logic [15:0] rx_enable_mask,
  output logic receiver_auto_enable,
  // interrupt
  output logic irq
);

  function automatic logic reg_hit(input logic [9:0] index, input logic [9:0] target);
    reg_hit = (index == target);
  endfunction

  // one byte register: a write to its index replaces it, otherwise it holds
  function automatic logic [7:0] byte_next(input logic we, input logic [7:0] wdata, input logic [7:0] cur);
    byte_next = we ? wdata : cur;
  endfunction

  // one term of the read and-or tree
  function automatic logic [7:0] lane_read(input logic hit, input logic [7:0] value);
    lane_read = hit ? value : 8'h00;
  endfunction

  exception_flag_pkg::reg_access_t acc;
  exception_flag_pkg::flag_write_t flag_wr;

  logic setup_phase;
  logic access_phase;
  logic wr_commit;
  logic aligned;
  logic mapped;
  logic lane0_we;

  logic hit_rx_low;
  logic hit_rx_high;
  logic hit_pend_low;
  logic hit_pend_mid;
  logic hit_pend_high;
  logic hit_sel_low;
  logic hit_sel_mid;
  logic hit_sel_high;
  logic hit_irq_status;
  logic hit_irq_enable;
  logic hit_irq_clear;

  logic [15:0] rx_enable_mask_q;
  logic [15:0] rx_enable_mask_d;
  logic rx_nonzero_q;
  logic rx_nonzero_d;
  logic rx_cleared_event;
  logic [23:0] rx_cleared_vec;
  logic [1:0] rx_hit;

  logic [23:0] select_q;
  logic [23:0] select_d;
  logic [2:0] sel_hit;
  logic [23:0] all_events;
  logic [23:0] pending;

  logic selected_hit;
  logic masked_hit;
  logic chan_a_q;
  logic chan_a_comp_q;

  logic [3:0] irq_events;
  logic [3:0] irq_status;
  logic [3:0] irq_enable;

  logic [7:0] rd_rx_low;
  logic [7:0] rd_rx_high;
  logic [7:0] rd_pend_low;
  logic [7:0] rd_pend_mid;
  logic [7:0] rd_pend_high;
  logic [7:0] rd_sel_low;
  logic [7:0] rd_sel_mid;
  logic [7:0] rd_sel_high;
  logic [7:0] rd_irq_status;
  logic [7:0] rd_irq_enable;
  logic [7:0] rdata_sel;
  logic [7:0] rdata_d;
  logic [31:0] prdata_q;
  logic pslverr_d;
  logic pslverr_q;

  genvar lane;

  // bus decode
  assign acc.index = paddr[11:2];
  assign acc.write = pwrite;
  assign acc.wdata = pwdata[7:0];
  // pready is tied high: no wait states, so every access phase is its last
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign aligned = (paddr[1:0] == 2'b00);
  // only byte lane 0 carries register data; upper lanes are reserved
  assign wr_commit = access_phase & acc.write & aligned & mapped;
  assign lane0_we = wr_commit & pstrb[0];

  assign hit_rx_low = reg_hit(acc.index, exception_flag_pkg::IDX_RX_ENABLE_MASK_LOW);
  assign hit_rx_high = reg_hit(acc.index, exception_flag_pkg::IDX_RX_ENABLE_MASK_HIGH);
  assign hit_pend_low = reg_hit(acc.index, exception_flag_pkg::IDX_EXCEPTION_PENDING_LOW);
  assign hit_pend_mid = reg_hit(acc.index, exception_flag_pkg::IDX_EXCEPTION_PENDING_MID);
  assign hit_pend_high = reg_hit(acc.index, exception_flag_pkg::IDX_EXCEPTION_PENDING_HIGH);
  assign hit_sel_low = reg_hit(acc.index, exception_flag_pkg::IDX_CHANNEL_A_SELECT_LOW);
  assign hit_sel_mid = reg_hit(acc.index, exception_flag_pkg::IDX_CHANNEL_A_SELECT_MID);
  assign hit_sel_high = reg_hit(acc.index, exception_flag_pkg::IDX_CHANNEL_A_SELECT_HIGH);
  assign hit_irq_status = reg_hit(acc.index, exception_flag_pkg::IDX_IRQ_STATUS);
  assign hit_irq_enable = reg_hit(acc.index, exception_flag_pkg::IDX_IRQ_ENABLE);
  assign hit_irq_clear = reg_hit(acc.index, exception_flag_pkg::IDX_IRQ_CLEAR);

  assign mapped = hit_rx_low | hit_rx_high | hit_pend_low | hit_pend_mid | hit_pend_high
                | hit_sel_low | hit_sel_mid | hit_sel_high
                | hit_irq_status | hit_irq_enable | hit_irq_clear;

  // receive enable mask, low byte first
  assign rx_hit = {hit_rx_high, hit_rx_low};

  generate
    for (lane = 0; lane < 2; lane++)
    begin : g_rx_mask
      assign rx_enable_mask_d[lane*8 +: 8] =
        byte_next(lane0_we & rx_hit[lane], acc.wdata, rx_enable_mask_q[lane*8 +: 8]);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_enable_mask_q <= exception_flag_pkg::RX_ENABLE_MASK_RST;
    else
      rx_enable_mask_q <= rx_enable_mask_d;
  end

  // the previous cycle's state, so a fall to zero gives exactly one pulse
  assign rx_nonzero_d = |rx_enable_mask_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_nonzero_q <= 1'b0;
    else
      rx_nonzero_q <= rx_nonzero_d;
  end

  // radio control turns the receiver on whenever any enable bit is set
  assign receiver_auto_enable = |rx_enable_mask_q;
  assign rx_enable_mask = rx_enable_mask_q;

  // the mask falling to zero is itself an exception source
  assign rx_cleared_event = rx_nonzero_q & ~(|rx_enable_mask_q);

  // channel A selection mask, one byte register per lane
  assign sel_hit = {hit_sel_high, hit_sel_mid, hit_sel_low};

  generate
    for (lane = 0; lane < 3; lane++)
    begin : g_select
      assign select_d[lane*8 +: 8] =
        byte_next(lane0_we & sel_hit[lane], acc.wdata, select_q[lane*8 +: 8]);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      select_q <= exception_flag_pkg::SELECT_RST;
    else
      select_q <= select_d;
  end

  // event collection; the unused top bit never reaches the flags
  assign rx_cleared_vec = 24'(rx_cleared_event) << exception_flag_pkg::EXC_RECEIVE_ENABLES_CLEARED;
  assign all_events = (exception_events | rx_cleared_vec)
                    & exception_flag_pkg::EXC_IMPLEMENTED;

  // pending flags, zero-write clear per byte
  assign flag_wr.byte_we = {lane0_we & hit_pend_high, lane0_we & hit_pend_mid, lane0_we & hit_pend_low};
  assign flag_wr.data = acc.wdata;

  exception_flag_bank u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_events(all_events),
    .wr(flag_wr),
    .pending(pending)
  );

  // channel A indications follow the event, not the pending flag, so a
  // pin pulses once per occurrence even while the flag is still set
  assign selected_hit = |(all_events & select_q);
  assign masked_hit = |(all_events & ~select_q & exception_flag_pkg::EXC_IMPLEMENTED);

  // both pins are flops, so each event gives one clean pulse a cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chan_a_q <= 1'b0;
    else
      chan_a_q <= selected_hit;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chan_a_comp_q <= 1'b0;
    else
      chan_a_comp_q <= masked_hit;
  end

  assign channel_a_indication = chan_a_q;
  assign channel_a_complement_indication = chan_a_comp_q;

  // interrupt sources
  // one status bit per flag byte, in the order low, mid, high
  generate
    for (lane = 0; lane < 3; lane++)
    begin : g_group
      assign irq_events[exception_flag_pkg::IRQ_GROUP_LOW + lane] = |all_events[lane*8 +: 8];
    end
  endgenerate
  assign irq_events[exception_flag_pkg::IRQ_CHANNEL_A] = selected_hit;

  // channel A hits get their own status bit, so software can tell a pin's cause
  irq_unit u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .events(irq_events),
    .enable_we(lane0_we & hit_irq_enable),
    .clear_we(lane0_we & hit_irq_clear),
    .wdata(acc.wdata[3:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );

  // read selection as an and-or tree; the write-only clear register reads zero
  assign rd_rx_low = lane_read(hit_rx_low, rx_enable_mask_q[7:0]);
  assign rd_rx_high = lane_read(hit_rx_high, rx_enable_mask_q[15:8]);
  assign rd_pend_low = lane_read(hit_pend_low, pending[7:0]);
  assign rd_pend_mid = lane_read(hit_pend_mid, pending[15:8]);
  assign rd_pend_high = lane_read(hit_pend_high, pending[23:16]);
  assign rd_sel_low = lane_read(hit_sel_low, select_q[7:0]);
  assign rd_sel_mid = lane_read(hit_sel_mid, select_q[15:8]);
  assign rd_sel_high = lane_read(hit_sel_high, select_q[23:16]);
  assign rd_irq_status = lane_read(hit_irq_status, {4'h0, irq_status});
  assign rd_irq_enable = lane_read(hit_irq_enable, {4'h0, irq_enable});
  assign rdata_sel = rd_rx_low | rd_rx_high | rd_pend_low | rd_pend_mid | rd_pend_high
                   | rd_sel_low | rd_sel_mid | rd_sel_high | rd_irq_status | rd_irq_enable;

  // read data and error are captured in the setup cycle so the access
  // cycle answers at once from flops; a flag set between the two cycles
  // shows on the next read
  assign rdata_d = (aligned & ~pwrite) ? rdata_sel : 8'h00;
  assign pslverr_d = ~(aligned & mapped);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= {24'h000000, exception_flag_pkg::RDATA_RST};
    else if (setup_phase)
      prdata_q <= {24'h000000, rdata_d};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr_q <= 1'b0;
    else if (setup_phase)
      pslverr_q <= pslverr_d;
  end

  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & access_phase;

endmodule

// ### hdl/irq_unit.sv
// interrupt status, enable and write-only clear with one level output.
// assumes event pulses and write strobes are synchronous to pclk.
module irq_unit (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // events
  input wire logic [3:0] events,
  // software access
  input wire logic enable_we,
  input wire logic clear_we,
  input wire logic [3:0] wdata,
  // state
  output logic [3:0] status,
  output logic [3:0] enable,
  output logic irq
);

  logic [3:0] status_q;
  logic [3:0] status_d;
  logic [3:0] enable_q;

  // writing one clears; an event in the same cycle keeps the bit
  assign status_d = (status_q & ~(clear_we ? wdata : 4'h0)) | events;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= exception_flag_pkg::IRQ_STATUS_RST;
      enable_q <= exception_flag_pkg::IRQ_ENABLE_RST;
    end
    else
    begin
      status_q <= status_d;
      if (enable_we)
        enable_q <= wdata;
    end
  end

  assign status = status_q;
  assign enable = enable_q;
  assign irq = |(status_q & enable_q);

endmodule

// ### shared/exception_flag_pkg.sv
// package: register indices, field positions, reset values and carrier types
// for the exception flag and channel A selection block.
// assumes an APB master with 32-bit data; each register index sits at byte address index*4.
package exception_flag_pkg;

  // register indices (byte address = index * 4)
  localparam logic [9:0] IDX_RX_ENABLE_MASK_LOW = 10'h00E;
  localparam logic [9:0] IDX_RX_ENABLE_MASK_HIGH = 10'h00F;
  localparam logic [9:0] IDX_EXCEPTION_PENDING_LOW = 10'h010;
  localparam logic [9:0] IDX_EXCEPTION_PENDING_MID = 10'h011;
  localparam logic [9:0] IDX_EXCEPTION_PENDING_HIGH = 10'h012;
  localparam logic [9:0] IDX_CHANNEL_A_SELECT_LOW = 10'h014;
  localparam logic [9:0] IDX_CHANNEL_A_SELECT_MID = 10'h015;
  localparam logic [9:0] IDX_CHANNEL_A_SELECT_HIGH = 10'h016;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h030;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h031;
  localparam logic [9:0] IDX_IRQ_CLEAR = 10'h032;

  // reset values
  localparam logic [15:0] RX_ENABLE_MASK_RST = 16'h0000;
  localparam logic [23:0] PENDING_RST = 24'h000000;
  localparam logic [23:0] SELECT_RST = 24'h000000;
  localparam logic [3:0] IRQ_STATUS_RST = 4'h0;
  localparam logic [3:0] IRQ_ENABLE_RST = 4'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // exception bit positions
  localparam int EXC_RADIO_IDLE_ENTERED = 0;
  localparam int EXC_TRANSMIT_FRAME_COMPLETE = 1;
  localparam int EXC_ACK_SENT = 2;
  localparam int EXC_TX_BUFFER_UNDERRUN = 3;
  localparam int EXC_TX_BUFFER_OVERRUN = 4;
  localparam int EXC_RX_BUFFER_UNDERRUN = 5;
  localparam int EXC_RX_BUFFER_OVERRUN = 6;
  localparam int EXC_RECEIVE_ENABLES_CLEARED = 7;
  localparam int EXC_RECEIVE_FRAME_COMPLETE = 8;
  localparam int EXC_RECEIVE_FRAME_PASSED_FILTER = 9;
  localparam int EXC_SOURCE_LOOKUP_COMPLETE = 10;
  localparam int EXC_SOURCE_LOOKUP_HIT = 11;
  localparam int EXC_RX_THRESHOLD_REACHED = 12;
  localparam int EXC_START_DELIMITER_SEEN = 13;
  localparam int EXC_CRYPTO_UNIT_LOW_DONE = 14;
  localparam int EXC_CRYPTO_UNIT_HIGH_DONE = 15;
  localparam int EXC_BAD_MEMORY_ADDRESS = 16;
  localparam int EXC_ILLEGAL_USE = 17;
  localparam int EXC_BAD_OPERAND = 18;
  localparam int EXC_SERIAL_PORT_FAULT = 19;
  localparam int EXC_SYNTH_UNLOCKED = 20;
  localparam int EXC_RECEIVE_FRAME_ABORTED = 21;
  localparam int EXC_RX_BUFFER_MOVE_TIMEOUT = 22;
  localparam int EXC_UNUSED = 23;
  localparam logic [23:0] EXC_IMPLEMENTED = 24'h7FFFFF;

  // interrupt status / enable / clear field positions
  localparam int IRQ_GROUP_LOW = 0;
  localparam int IRQ_GROUP_MID = 1;
  localparam int IRQ_GROUP_HIGH = 2;
  localparam int IRQ_CHANNEL_A = 3;

  // one register access taken from the bus
  typedef struct packed {
    logic [9:0] index;
    logic write;
    logic [7:0] wdata;
  } reg_access_t;

  // zero-write clear request for the pending flags, one enable per byte
  typedef struct packed {
    logic [2:0] byte_we;
    logic [7:0] data;
  } flag_write_t;

endpackage

// ### verif/exception_flag_mask_unit_monitor.sv
// checker for the exception flag and channel A unit, bound to its ports.
// assumes one clock, pclk, and the async active-low reset presetn.
module exception_flag_mask_unit_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events and outputs
  input wire logic [23:0] exception_events,
  input wire logic channel_a_indication,
  input wire logic channel_a_complement_indication,
  input wire logic [15:0] rx_enable_mask,
  input wire logic receiver_auto_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire rxh_wr = acc && pwrite && paddr == 12'h03C && pstrb[0];
  wire rx_wr = acc && pwrite && (paddr == 12'h038 || paddr == 12'h03C);
  wire ind = channel_a_indication || channel_a_complement_indication;

  ind_any_a: assert property (|exception_events[22:0] |=> ind)
    else $error("no channel indication after an event");
  // a receive mask falling to zero is an event of its own, seen one cycle after the fall
  ind_quiet_a: assert property (!(|exception_events[22:0]) && !$fell(|rx_enable_mask) |=> !ind)
    else $error("channel indication without an event");
  rx_write_a: assert property (rxh_wr |=> rx_enable_mask[15:8] == $past(pwdata[7:0]))
    else $error("rx mask high byte not written");
  rx_hold_a: assert property (!rx_wr |=> $stable(rx_enable_mask))
    else $error("rx mask changed without a write");
  rx_auto_a: assert property (receiver_auto_enable == |rx_enable_mask)
    else $error("receiver enable does not follow the mask");
  err_phase_a: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  err_align_a: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  rd_upper_a: assert property (prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  ready_on_a: assert property (pready)
    else $error("ready low");

  cover property (rxh_wr);
  cover property (channel_a_indication);
  cover property (channel_a_complement_indication);
  cover property (pslverr);
endmodule

// ### verif/exception_flag_mask_unit_test.sv
// self-checking bench: host model drives apb, bench drives event pulses.
// assumes the unit answers reads with prdata and pslverr at the access edge.
module exception_flag_mask_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic channel_a_indication, channel_a_complement_indication, receiver_auto_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [3:0] pstrb;
  logic [23:0] exception_events;
  logic [15:0] rx_enable_mask;
  logic [32:0] notes [$];
  logic [32:0] exp;
  int err_total = 0;
  int compares = 0;

  exception_flag_mask_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exception_events(exception_events), .channel_a_indication(channel_a_indication),
    .channel_a_complement_indication(channel_a_complement_indication), .rx_enable_mask(rx_enable_mask),
    .receiver_auto_enable(receiver_auto_enable), .irq(irq));
  host_model i_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] v);
    compares++;
    if (v !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, v);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    notes.push_back(e);
    i_host.xfer(a, 1'b0, 32'h00000000);
  endtask
  task automatic pulse(input logic [23:0] e);
    @(posedge pclk);
    exception_events <= e;
    @(posedge pclk);
    exception_events <= 24'h000000;
    #1;
  endtask
  task end_sim;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // read results are taken from the oldest note at the access edge
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
    begin
      exp = (notes.size() > 0) ? notes.pop_front() : 33'h1FFFFFFFF;
      chk("read data", exp, {pslverr, prdata});
    end

  initial
  begin
    #100000;
    err_total++;
    end_sim();
  end

  initial
  begin
    logic [31:0] r, s;
    logic [11:0] rst_regs [8];
    rst_regs = '{12'h038, 12'h03C, 12'h040, 12'h044, 12'h048, 12'h050, 12'h054, 12'h058};
    presetn = 1'b0;
    exception_events = 24'h000000;
    seed = 32'hF29221BD;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(rst_regs[i], 33'h000000000);
    seed = lfsr(seed);
    r = seed | 32'h00000001;
    wr(12'h03C, r);
    rd(12'h03C, {25'h0, r[7:0]});
    seed = lfsr(seed);
    s = seed;
    wr(12'h050, s);
    wr(12'h054, s >> 8);
    wr(12'h058, s >> 16);
    rd(12'h050, {25'h0, s[7:0]});
    rd(12'h054, {25'h0, s[15:8]});
    rd(12'h058, {25'h0, s[23:16]});
    // every event line in turn, bit 23 must stay silent
    for (int i = 0; i < 24; i++)
    begin
      pulse(24'h000001 << i);
      chk("indication", {32'h0, i < 23 && s[i]}, {32'h0, channel_a_indication});
      chk("complement", {32'h0, i < 23 && !s[i]}, {32'h0, channel_a_complement_indication});
    end
    rd(12'h040, 33'h0000000FF);
    rd(12'h044, 33'h0000000FF);
    rd(12'h048, 33'h00000007F);
    wr(12'h040, 32'h000000FF);
    rd(12'h040, 33'h0000000FF);
    seed = lfsr(seed);
    r = seed;
    wr(12'h044, r);
    rd(12'h044, {25'h0, r[7:0]});
    fork
      wr(12'h048, 32'h00000000);
      begin
        repeat (2) @(posedge pclk);
        exception_events <= 24'h010000;
        @(posedge pclk);
        exception_events <= 24'h000000;
      end
    join
    rd(12'h048, 33'h000000001);
    wr(12'h040, 32'h00000000);
    rd(12'h040, 33'h000000000);
    wr(12'h03C, 32'h00000000);
    repeat (3) @(posedge pclk);
    rd(12'h040, 33'h000000080);
    #1;
    chk("irq masked", 33'h0, {32'h0, irq});
    wr(12'h0C4, 32'h0000000F);
    #1;
    chk("irq enabled", 33'h1, {32'h0, irq});
    rd(12'h0C4, 33'h00000000F);
    rd(12'h0C8, 33'h000000000);
    wr(12'h0C8, 32'h0000000F);
    #1;
    chk("irq cleared", 33'h0, {32'h0, irq});
    pulse(24'h000001);
    @(posedge pclk);
    #1;
    chk("irq raised", 33'h1, {32'h0, irq});
    rd(12'h0C0, {29'h0, s[0], 3'b001});
    rd(12'h0FC, 33'h100000000);
    rd(12'h041, 33'h100000000);
    repeat (3) @(posedge pclk);
    chk("notes left", 33'h0, notes.size());
    end_sim();
  end
endmodule

bind exception_flag_mask_unit exception_flag_mask_unit_monitor i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .exception_events(exception_events),
  .channel_a_indication(channel_a_indication),
  .channel_a_complement_indication(channel_a_complement_indication),
  .rx_enable_mask(rx_enable_mask), .receiver_auto_enable(receiver_auto_enable));

// ### verif/host_model.sv
// host side: an apb master with one transfer task.
// assumes pclk from the bench; waits on pready, however late it comes.
module host_model (
  // bus
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
  end
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    // released data must not look like a held value
    pwdata <= ~d;
  endtask
endmodule
